/* core/ifc_edge_det.v */
// Polarity-selectable edge detector for one external interrupt
`timescale 1ns/1ps
module ifc_edge_det (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Synchronised level and polarity
   input wire lvl_i,
   input wire neg_i,
   // One-cycle edge pulse
   output wire edge_o
);
   // ------------------------------------------------------------
   // Previous level
   // ------------------------------------------------------------
   reg prev; // Level one cycle ago

   // Remember last level
   always @(posedge clk_i) begin
      if (rst_i) begin
         prev <= 1'b0;
      end else begin
         prev <= lvl_i;
      end
   end

   // Negative edge when polarity is 1, else positive edge
   assign edge_o = neg_i ? (prev & ~lvl_i) : (~prev & lvl_i); // RQ7
endmodule // ifc_edge_det

/* core/ifc_sync3.v */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module ifc_sync3 (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Async input and filtered level
   input wire d_i,
   output reg q_o
);
   // ------------------------------------------------------------
   // Synchroniser chain
   // ------------------------------------------------------------
   reg s1; // First stage, read only by s2
   reg s2; // Second stage
   reg s3; // Third stage

   // Shift chain and accept when stages two and three agree
   always @(posedge clk_i) begin
      if (rst_i) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         q_o <= 1'b0;
      end else begin
         s1 <= d_i;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            q_o <= s3;
         end
      end
   end
endmodule // ifc_sync3

/* core/ifc_top.v */
// Interrupt trap status, vector/edge control and flag registers
`timescale 1ns/1ps
`include "ifc_consts.vh"
module ifc_top (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Register port
   input wire [1:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [15:0] rdata_o,
   // Trap events from the core, one-cycle pulses
   input wire addr_err_trap_i,
   input wire stack_err_trap_i,
   input wire osc_fail_trap_i,
   // Timed interrupt-disable status from the core
   input wire timed_disable_i,
   // External interrupt pins, asynchronous
   input wire [4:0] ext_irq_i,
   // Peripheral request pulses, same clock
   input wire [15:0] req_a_i,
   input wire [15:0] req_b_i,
   // Control outputs
   output reg alt_vector_table_select_o,
   output reg [4:0] ext_irq_edge_o,
   output reg [15:0] flags_a_o,
   output reg [15:0] flags_b_o
);
   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   reg address_error_trap_flag; // Trap status bit 3
   reg stack_error_trap_flag; // Trap status bit 2
   reg osc_failure_trap_flag; // Trap status bit 1
   reg alt_vector_table_select; // Vector table choice
   reg [4:0] ext_irq_polarity; // 1 selects negative edge
   reg [15:0] irq_flags_bank_a; // Flag bank A
   reg [15:0] irq_flags_bank_b; // Flag bank B
   reg timed_irq_disable_active; // Registered copy of core status
   wire [4:0] ext_sync; // Synchronised pins
   wire [4:0] ext_edge; // Edge pulses
   reg [15:0] next_a; // Next bank A
   reg [15:0] next_b; // Next bank B
   reg [15:0] set_a; // Set terms bank A
   reg [15:0] set_b; // Set terms bank B

   // Write strobe decode
   function wr_hit;
      input [1:0] a;
      input [1:0] off;
      input w;
      begin
         wr_hit = w & (a == off);
      end
   endfunction

   // ------------------------------------------------------------
   // External interrupt inputs
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `IFC_EXT_N; gi = gi + 1) begin : g_ext
         // Pin crossing into the clock domain
         ifc_sync3 u_sync (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .d_i(ext_irq_i[gi]),
            .q_o(ext_sync[gi])
         );
         // Edge per selected polarity
         ifc_edge_det u_edge (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .lvl_i(ext_sync[gi]),
            .neg_i(ext_irq_polarity[gi]),
            .edge_o(ext_edge[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Flag set terms
   // ------------------------------------------------------------
   // Map sources onto banks; unimplemented positions never set
   always @* begin
      set_a = req_a_i & `IFC_FLAGA_MASK; // RQ9 RQ10
      set_a[0] = ext_edge[0]; // RQ8
      set_b = req_b_i & `IFC_FLAGB_MASK; // RQ11 RQ12 RQ14
      set_b[13] = ext_edge[2]; // RQ11
      set_b[4] = ext_edge[1]; // RQ12
   end

   // Software write, then hardware set wins over clear
   always @* begin
      next_a = irq_flags_bank_a;
      next_b = irq_flags_bank_b;
      if (wr_hit(addr_i, `IFC_OFF_FLAGA, wr_i)) begin
         next_a = wdata_i; // RQ13
      end
      if (wr_hit(addr_i, `IFC_OFF_FLAGB, wr_i)) begin
         next_b = wdata_i; // RQ13
      end
      next_a = (next_a | set_a) & `IFC_FLAGA_MASK; // RQ15 RQ4
      next_b = (next_b | set_b) & `IFC_FLAGB_MASK; // RQ15 RQ4
   end

   // ------------------------------------------------------------
   // Register update
   // ------------------------------------------------------------
   // All state resets to zero
   always @(posedge clk_i) begin
      if (rst_i) begin
         address_error_trap_flag <= 1'b0;
         stack_error_trap_flag <= 1'b0;
         osc_failure_trap_flag <= 1'b0;
         alt_vector_table_select <= 1'b0;
         ext_irq_polarity <= 5'h00;
         irq_flags_bank_a <= `IFC_RST_VAL; // RQ13
         irq_flags_bank_b <= `IFC_RST_VAL; // RQ13
         timed_irq_disable_active <= 1'b0;
      end else begin
         timed_irq_disable_active <= timed_disable_i; // RQ6
         irq_flags_bank_a <= next_a;
         irq_flags_bank_b <= next_b;
         // Trap bits: writable, trap event wins
         if (wr_hit(addr_i, `IFC_OFF_TRAP, wr_i)) begin
            address_error_trap_flag <= wdata_i[`IFC_TRAP_ADDR_BIT] | addr_err_trap_i; // RQ1
            stack_error_trap_flag <= wdata_i[`IFC_TRAP_STK_BIT] | stack_err_trap_i; // RQ2
            osc_failure_trap_flag <= wdata_i[`IFC_TRAP_OSC_BIT] | osc_fail_trap_i; // RQ3
         end else begin
            address_error_trap_flag <= address_error_trap_flag | addr_err_trap_i; // RQ1
            stack_error_trap_flag <= stack_error_trap_flag | stack_err_trap_i; // RQ2
            osc_failure_trap_flag <= osc_failure_trap_flag | osc_fail_trap_i; // RQ3
         end
         // Control register; bit 14 ignores writes
         if (wr_hit(addr_i, `IFC_OFF_VEC, wr_i)) begin
            alt_vector_table_select <= wdata_i[`IFC_VEC_ALT_BIT]; // RQ5
            ext_irq_polarity <= wdata_i[4:0]; // RQ7
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs and read port
   // ------------------------------------------------------------
   // Registered copies toward the core and read data
   always @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= 16'h0000;
         alt_vector_table_select_o <= 1'b0;
         ext_irq_edge_o <= 5'h00;
         flags_a_o <= 16'h0000;
         flags_b_o <= 16'h0000;
      end else begin
         alt_vector_table_select_o <= alt_vector_table_select; // RQ5
         ext_irq_edge_o <= ext_edge; // RQ7
         flags_a_o <= next_a;
         flags_b_o <= next_b;
         if (rd_i) begin
            case (addr_i)
               // Trap status, bit 0 zero
               `IFC_OFF_TRAP: begin
                  rdata_o <= {12'h000, address_error_trap_flag, stack_error_trap_flag,
                              osc_failure_trap_flag, 1'b0}; // RQ4
               end
               // Vector and edge control, bits 13..5 zero
               `IFC_OFF_VEC: begin
                  rdata_o <= {alt_vector_table_select, timed_irq_disable_active, 9'h000,
                              ext_irq_polarity}; // RQ4 RQ6
               end
               `IFC_OFF_FLAGA: begin
                  rdata_o <= irq_flags_bank_a;
               end
               `IFC_OFF_FLAGB: begin
                  rdata_o <= irq_flags_bank_b;
               end
               default: begin
                  rdata_o <= 16'h0000;
               end
            endcase
         end else begin
            rdata_o <= 16'h0000;
         end
      end
   end
endmodule // ifc_top

/* dv/ifc_src_model.sv */
// Behavioural core and peripheral sources that drive the block
`timescale 1ns/1ps
module ifc_src_model (
   // Clock
   input wire clk_i,
   // Source outputs
   output reg [2:0] trap_o,
   output reg dis_o,
   output reg [4:0] pin_o,
   output reg [15:0] req_a_o,
   output reg [15:0] req_b_o
);
   // Quiet sources at time zero
   initial begin
      trap_o = 3'h0;
      dis_o = 1'b0;
      pin_o = 5'h00;
      req_a_o = 16'h0000;
      req_b_o = 16'h0000;
   end
   // One-cycle request and trap pulse
   task pulse(input [15:0] a, input [15:0] b, input [2:0] t);
      @(posedge clk_i);
      req_a_o <= a;
      req_b_o <= b;
      trap_o <= t;
      @(posedge clk_i);
      req_a_o <= 16'h0000;
      req_b_o <= 16'h0000;
      trap_o <= 3'h0;
   endtask
   // Pin levels and timed disable level
   task set_pins(input [4:0] v);
      @(posedge clk_i);
      pin_o <= v;
   endtask
   task set_dis(input v);
      @(posedge clk_i);
      dis_o <= v;
   endtask
endmodule // ifc_src_model

/* dv/ifc_top_sva.sv */
// Assertions on the flag and control register block
`timescale 1ns/1ps
module ifc_top_sva (
   input wire clk_i, input wire rst_i,
   input wire [1:0] addr_i, input wire [15:0] wdata_i,
   input wire wr_i, input wire rd_i, input wire [15:0] rdata_o,
   input wire addr_err_trap_i, input wire stack_err_trap_i, input wire osc_fail_trap_i,
   input wire timed_disable_i, input wire [4:0] ext_irq_i,
   input wire [15:0] req_a_i, input wire [15:0] req_b_i,
   input wire alt_vector_table_select_o, input wire [4:0] ext_irq_edge_o,
   input wire [15:0] flags_a_o, input wire [15:0] flags_b_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Trap pulse followed by a trap register read
   sequence s_trap;
      addr_err_trap_i ##1 !wr_i ##1 (rd_i && addr_i == 2'h0);
   endsequence
   a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000) else $error("rdata not idle");
   a_trap_set: assert property (s_trap |=> rdata_o[3]) else $error("trap bit not set");
   a_trap_rsvd: assert property (rd_i && addr_i == 2'h0 |=> (rdata_o & 16'hfff1) == 16'h0000)
      else $error("trap reserved bits");
   a_vec_read: assert property (rd_i && addr_i == 2'h1 |=> rdata_o[13:5] == 9'h000
      && rdata_o[14] == $past(timed_disable_i, 2)) else $error("ctrl read wrong");
   a_alt_copy: assert property (wr_i && addr_i == 2'h1 |=> ##1
      alt_vector_table_select_o == $past(wdata_i[15], 2)) else $error("alt select wrong");
   a_req_a: assert property (|(req_a_i & 16'h7ffe) |=> (flags_a_o & $past(req_a_i) & 16'h7ffe)
      == ($past(req_a_i) & 16'h7ffe)) else $error("bank a request lost");
   a_req_b: assert property (|(req_b_i & 16'hdfeb) |=> (flags_b_o & $past(req_b_i) & 16'hdfeb)
      == ($past(req_b_i) & 16'hdfeb)) else $error("bank b request lost");
   a_flag_hold: assert property (!(wr_i && addr_i == 2'h2) |=> (flags_a_o & $past(flags_a_o))
      == $past(flags_a_o)) else $error("flag dropped");
   a_flag_rsvd: assert property (!flags_a_o[15] && !flags_b_o[2]) else $error("reserved flag");
   a_ext_flag: assert property (ext_irq_edge_o[0] |-> flags_a_o[0]) else $error("ext0 flag");
endmodule // ifc_top_sva
bind ifc_top ifc_top_sva u_sva (.*);

/* dv/ifc_top_tb.sv */
// Self-checking bench for the flag and control register block
`timescale 1ns/1ps
module ifc_top_tb;
   reg clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg [1:0] addr_i = 2'h0;
   reg [15:0] wdata_i = 16'h0000;
   reg wr_i = 1'b0;
   reg rd_i = 1'b0;
   wire [15:0] rdata_o, flags_a_o, flags_b_o, req_a, req_b;
   wire [2:0] trap;
   wire [4:0] pins, edge_o;
   wire dis, alt_o;
   integer errors = 0;
   integer cmp_count = 0;
   integer cycles = 0;
   integer i;
   reg [4:0] seen;
   ifc_src_model src (.clk_i(clk_i), .trap_o(trap), .dis_o(dis), .pin_o(pins), .req_a_o(req_a), .req_b_o(req_b));
   ifc_top dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .addr_err_trap_i(trap[2]), .stack_err_trap_i(trap[1]), .osc_fail_trap_i(trap[0]),
      .timed_disable_i(dis), .ext_irq_i(pins), .req_a_i(req_a), .req_b_i(req_b),
      .alt_vector_table_select_o(alt_o), .ext_irq_edge_o(edge_o), .flags_a_o(flags_a_o), .flags_b_o(flags_b_o));
   // 25 MHz clock
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   // Hang guard
   always @(posedge clk_i) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         errors = errors + 1;
         tally_and_finish;
      end
   end
   task tally_and_finish;
      $display("Comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task check(input [15:0] exp, input [15:0] got, input string what);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("ERROR %0s expected %h seen %h", what, exp, got);
      end
   endtask
   // Register write and read cycles
   task wr(input [1:0] a, input [15:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input [1:0] a, input [15:0] exp, input string what);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 check(exp, rdata_o, what);
   endtask
   task t_reset;
      for (i = 0; i < 4; i = i + 1) rd(i[1:0], 16'h0000, "reset value");
      $display("t_reset done");
   endtask
   task t_vec;
      wr(2'h1, 16'hffff);
      rd(2'h1, 16'h801f, "ctrl");
      check(16'h0001, {15'h0000, alt_o}, "alt select");
      src.set_dis(1'b1);
      rd(2'h1, 16'hc01f, "ctrl busy");
      src.set_dis(1'b0);
      wr(2'h1, 16'h0000);
      rd(2'h1, 16'h0000, "ctrl clear");
      check(16'h0000, {15'h0000, alt_o}, "alt select");
      $display("t_vec done");
   endtask
   task t_trap;
      for (i = 0; i < 3; i = i + 1) begin
         src.pulse(16'h0000, 16'h0000, 3'h4 >> i);
         rd(2'h0, 16'h0008 >> i, "trap bit");
         wr(2'h0, 16'h0000);
      end
      wr(2'h0, 16'hffff);
      rd(2'h0, 16'h000e, "trap mask");
      wr(2'h0, 16'h0000);
      $display("t_trap done");
   endtask
   task t_flags;
      src.pulse(16'hffff, 16'hffff, 3'h0);
      rd(2'h2, 16'h7ffe, "bank a");
      rd(2'h3, 16'hdfeb, "bank b");
      wr(2'h2, 16'h0000);
      wr(2'h3, 16'h0000);
      rd(2'h2, 16'h0000, "bank a clear");
      rd(2'h3, 16'h0000, "bank b clear");
      fork
         src.pulse(16'h0002, 16'h0001, 3'h0);
         wr(2'h2, 16'h0000);
      join
      repeat (5) @(posedge clk_i);
      rd(2'h2, 16'h0002, "set beats clear");
      rd(2'h3, 16'h0001, "flag held");
      wr(2'h2, 16'h0000);
      wr(2'h3, 16'h0000);
      $display("t_flags done");
   endtask
   task t_ext;
      wr(2'h1, 16'h0002);
      seen = 5'h00;
      src.set_pins(5'h1f);
      for (i = 0; i < 8; i = i + 1) begin
         @(posedge clk_i);
         seen = seen | edge_o;
      end
      check(16'h001d, {11'h000, seen}, "rise edges");
      check(16'h0001, flags_a_o, "flags a out");
      rd(2'h2, 16'h0001, "ext0 rise");
      rd(2'h3, 16'h2000, "ext1 ext2 rise");
      seen = 5'h00;
      src.set_pins(5'h00);
      for (i = 0; i < 8; i = i + 1) begin
         @(posedge clk_i);
         seen = seen | edge_o;
      end
      check(16'h0002, {11'h000, seen}, "fall edges");
      check(16'h2010, flags_b_o, "flags b out");
      rd(2'h3, 16'h2010, "ext1 fall");
      $display("t_ext done");
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_vec;
      t_trap;
      t_flags;
      t_ext;
      tally_and_finish;
   end
endmodule // ifc_top_tb

/* pkg/ifc_consts.vh */
// Constants for the interrupt flag and control register block
// How it works
// RQ1: Address error trap sets bit 3
// RQ2: Stack error trap sets bit 2
// RQ3: Oscillator failure trap sets bit 1
// RQ4: Unimplemented bits always read zero
// RQ5: Bit 15 selects alternate vector table
// RQ6: Bit 14 shows timed disable, read-only
// RQ7: Bits 4..0 pick external edge polarity
// RQ8: External interrupt 0 flag at bit 0
// RQ9: Bank A upper byte request flags
// RQ10: Bank A lower bits request flags
// RQ11: Bank B upper byte request flags
// RQ12: Bank B bits 7..4 request flags
// RQ13: Flags reset zero, software read/write
// RQ14: Change notify and I2C flags bank B
// RQ15: Flag holds until cleared; set wins
`ifndef IFC_CONSTS_VH
`define IFC_CONSTS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define IFC_ADDR_W 2
`define IFC_OFF_TRAP 2'h0
`define IFC_OFF_VEC 2'h1
`define IFC_OFF_FLAGA 2'h2
`define IFC_OFF_FLAGB 2'h3

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define IFC_TRAP_ADDR_BIT 3
`define IFC_TRAP_STK_BIT 2
`define IFC_TRAP_OSC_BIT 1
`define IFC_VEC_ALT_BIT 15
`define IFC_VEC_DIS_BIT 14
`define IFC_EXT_N 5

// ------------------------------------------------------------
// Implemented-bit masks and reset values
// ------------------------------------------------------------
`define IFC_TRAP_MASK 16'h000e
`define IFC_VEC_MASK 16'hc01f
`define IFC_FLAGA_MASK 16'h7fff
`define IFC_FLAGB_MASK 16'hfffb
`define IFC_RST_VAL 16'h0000

`endif
